// >>> src/mfgp_map.svh
// Offsets, field codes, reset values and timing figures of the pin block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef MFGP_MAP_SVH
`define MFGP_MAP_SVH

`define MFGP_NUM_PINS 5
`define MFGP_DW 16
`define MFGP_AW 4
`define MFGP_FN_W 6

// Word offsets: pin control registers sit at offset (pin number - 1).
`define MFGP_OFS_CTRL_FIRST 4'h0
`define MFGP_OFS_CTRL_LAST 4'h4
`define MFGP_OFS_PIN_STAT 4'h5
`define MFGP_OFS_IRQ_STAT 4'h6
`define MFGP_OFS_IRQ_EN 4'h7
`define MFGP_OFS_IRQ_CLR 4'h8

// Function select codes.
`define MFGP_FN_GP_OUT 6'h00
`define MFGP_FN_BCLK 6'h01
`define MFGP_FN_IRQ 6'h02
`define MFGP_FN_GP_IN 6'h03
`define MFGP_FN_MB_CUR 6'h04
`define MFGP_FN_MB_SHORT 6'h05
`define MFGP_FN_DMIC 6'h06
`define MFGP_FN_FLL_LOCK 6'h08
`define MFGP_FN_FLL_CLK 6'h09

// Pin index of the special pins (zero based).
`define MFGP_PIN_DMIC_CLK 0
`define MFGP_PIN_DMIC_DATA 1
`define MFGP_PIN_IRQ 3
`define MFGP_PIN_BCLK 4

// Control register reset values.
`define MFGP_CTRL_RST_GEN 16'h00a8
`define MFGP_CTRL_RST_IRQ 16'h02a8
`define MFGP_CTRL_RST_BCLK 16'h01a8
`define MFGP_IRQ_EN_RST 5'h00

// Debounce timing.
`define MFGP_CLK_PERIOD_NS 100
`define MFGP_DB_TICK_NS 1000000
`define MFGP_DB_STABLE_TICKS 4

`endif

// >>> src/mfgp_pkg.sv
// Types shared by the pin block modules.
// Assumes the map header is on the include path.
`include "mfgp_map.svh"

package mfgp_pkg;

  typedef struct packed {
    logic [`MFGP_FN_W-1:0] pin_function_select;
    logic pin_direction;
    logic output_drive_type;
    logic input_polarity;
    logic output_level;
    logic pulldown_enable;
    logic pullup_enable;
    logic interrupt_trigger_mode;
    logic debounce_enable;
  } mfgp_pin_cfg_t;

  typedef struct packed {
    logic device_irq;
    logic mb_current_detect;
    logic mb_short_detect;
    logic fll_lock;
    logic fll_clock;
    logic digital_mic_clock;
    logic bclk_out;
    logic bclk_oe;
  } mfgp_func_in_t;

  typedef struct packed {
    logic digital_mic_data;
    logic digital_mic_data_valid;
    logic bclk_in;
    logic bclk_on_pin;
  } mfgp_func_out_t;

endpackage

// >>> src/mfgp_debounce.sv
// Synchroniser and per-pin debounce counters for the pin inputs.
// Assumes one clock and a reset already released synchronously.
`timescale 1ns/1ps

module mfgp_debounce
  import mfgp_pkg::*;
#(
  parameter int PINS = `MFGP_NUM_PINS,
  parameter int TICK_CYCLES = 10000,
  parameter int STABLE_TICKS = `MFGP_DB_STABLE_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [PINS-1:0] raw_i,
  output logic [PINS-1:0] sync_o,
  output logic [PINS-1:0] deb_o
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int CW = $clog2(STABLE_TICKS + 1);

  logic [PINS-1:0] meta_q;
  logic [PINS-1:0] sync_q;
  logic [TW-1:0] tick_cnt_q;
  logic [TW-1:0] tick_cnt_d;
  logic tick;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

  always_comb begin
    tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // A change is accepted only after it has held for STABLE_TICKS ticks.
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    logic lvl_q;
    logic lvl_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    always_comb begin
      lvl_d = lvl_q;
      cnt_d = cnt_q;
      if (sync_q[p] == lvl_q) begin
        cnt_d = '0;
      end else if (tick) begin
        if (cnt_q == CW'(STABLE_TICKS - 1)) begin
          lvl_d = sync_q[p];
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        lvl_q <= 1'b0;
        cnt_q <= '0;
      end else begin
        lvl_q <= lvl_d;
        cnt_q <= cnt_d;
      end
    end
    assign deb_o[p] = lvl_q;
  end

endmodule

// >>> src/mfgp_top.sv
// Five multi-function pins: function mux, pad drive, input path, interrupts.
// Assumes pads resolve out, oe and pull enables outside, synchronous inputs.
`timescale 1ns/1ps

module mfgp_top
  import mfgp_pkg::*;
#(
  parameter int PINS = `MFGP_NUM_PINS,
  parameter int DB_TICK_CYCLES = `MFGP_DB_TICK_NS / `MFGP_CLK_PERIOD_NS,
  parameter int DB_STABLE_TICKS = `MFGP_DB_STABLE_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [`MFGP_AW-1:0] addr_i,
  input wire logic [`MFGP_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`MFGP_DW-1:0] rdata_o,
  input wire logic [PINS-1:0] pad_in_i,
  output logic [PINS-1:0] pad_out_o,
  output logic [PINS-1:0] pad_oe_o,
  output logic [PINS-1:0] pullup_en_o,
  output logic [PINS-1:0] pulldown_en_o,
  input mfgp_func_in_t func_i,
  output mfgp_func_out_t func_o,
  output logic irq_o
);

  logic rst_meta_q;
  logic rst_sync_n_q;
  mfgp_pin_cfg_t cfg_q [PINS];
  mfgp_pin_cfg_t cfg_d [PINS];
  logic [PINS-1:0] ien_q;
  logic [PINS-1:0] ien_d;
  logic [PINS-1:0] ists_q;
  logic [PINS-1:0] ists_d;
  logic [PINS-1:0] stat_prev_q;
  logic [PINS-1:0] stat_prev_d;
  logic [`MFGP_DW-1:0] rdata_q;
  logic [`MFGP_DW-1:0] rdata_d;
  logic [PINS-1:0] in_sync;
  logic [PINS-1:0] in_deb;
  logic [PINS-1:0] pin_stat;
  logic wr_ctrl;
  logic [`MFGP_AW-1:0] ctrl_idx;

  // Reset is asserted at once and released two edges later.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  mfgp_debounce #(
    .PINS(PINS),
    .TICK_CYCLES(DB_TICK_CYCLES),
    .STABLE_TICKS(DB_STABLE_TICKS)
  ) u_deb (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_n_q),
    .raw_i(pad_in_i),
    .sync_o(in_sync),
    .deb_o(in_deb)
  );

  assign wr_ctrl = wr_i && (addr_i <= `MFGP_OFS_CTRL_LAST);
  assign ctrl_idx = addr_i - `MFGP_OFS_CTRL_FIRST;

  // Pin output path and input status, one copy per pin.
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    logic drive_val;
    logic is_out;
    logic bclk_mode;
    logic raw_lvl;
    always_comb begin
      bclk_mode = 1'b0;
      drive_val = 1'b0;
      is_out = !cfg_q[p].pin_direction;
      case (cfg_q[p].pin_function_select)
        `MFGP_FN_GP_OUT: drive_val = cfg_q[p].output_level;
        `MFGP_FN_IRQ: drive_val = irq_o | func_i.device_irq;
        `MFGP_FN_MB_CUR: drive_val = func_i.mb_current_detect;
        `MFGP_FN_MB_SHORT: drive_val = func_i.mb_short_detect;
        `MFGP_FN_FLL_LOCK: drive_val = func_i.fll_lock;
        `MFGP_FN_FLL_CLK: drive_val = func_i.fll_clock;
        `MFGP_FN_DMIC: begin
          if (p == `MFGP_PIN_DMIC_CLK) begin
            drive_val = func_i.digital_mic_clock;
          end
        end
        `MFGP_FN_BCLK: begin
          bclk_mode = (p == `MFGP_PIN_BCLK);
        end
        default: drive_val = 1'b0;
      endcase
    end
    // Bit clock mode overrides the direction, drive type, level and pull fields of the pin.
    always_comb begin
      if (bclk_mode) begin
        pad_out_o[p] = func_i.bclk_out;
        pad_oe_o[p] = func_i.bclk_oe;
        pullup_en_o[p] = 1'b0;
        pulldown_en_o[p] = 1'b0;
      end else begin
        // Open drain only ever pulls low, so the pad never fights a pull-up.
        if (cfg_q[p].output_drive_type) begin
          pad_out_o[p] = 1'b0;
          pad_oe_o[p] = is_out && !drive_val;
        end else begin
          pad_out_o[p] = drive_val;
          pad_oe_o[p] = is_out;
        end
        pullup_en_o[p] = cfg_q[p].pullup_enable &&
                         !cfg_q[p].pulldown_enable;
        pulldown_en_o[p] = cfg_q[p].pulldown_enable &&
                           !cfg_q[p].pullup_enable;
      end
    end
    always_comb begin
      raw_lvl = cfg_q[p].debounce_enable ? in_deb[p] : in_sync[p];
      pin_stat[p] = cfg_q[p].input_polarity ? raw_lvl : !raw_lvl;
    end
  end

  // Pin two's level always reaches the microphone data output; only the valid flag needs that code.
  always_comb begin
    func_o.digital_mic_data = in_sync[`MFGP_PIN_DMIC_DATA];
    func_o.digital_mic_data_valid =
      (cfg_q[`MFGP_PIN_DMIC_DATA].pin_function_select == `MFGP_FN_DMIC);
    func_o.bclk_on_pin =
      (cfg_q[`MFGP_PIN_BCLK].pin_function_select == `MFGP_FN_BCLK);
    func_o.bclk_in = in_sync[`MFGP_PIN_BCLK];
  end

  // Configuration registers, one copy per pin with its own reset word.
  // Pins four and five wake up in their special functions.
  for (genvar p = 0; p < PINS; p++) begin : g_cfg
    localparam mfgp_pin_cfg_t RST_VAL =
      (p == `MFGP_PIN_IRQ) ? mfgp_pin_cfg_t'(`MFGP_CTRL_RST_IRQ) :
      (p == `MFGP_PIN_BCLK) ? mfgp_pin_cfg_t'(`MFGP_CTRL_RST_BCLK) :
      mfgp_pin_cfg_t'(`MFGP_CTRL_RST_GEN);
    always_comb begin
      cfg_d[p] = cfg_q[p];
      if (wr_ctrl && (ctrl_idx == `MFGP_AW'(p))) begin
        cfg_d[p] =
          mfgp_pin_cfg_t'(wdata_i[$bits(mfgp_pin_cfg_t)-1:0]);
      end
    end
    always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
        cfg_q[p] <= RST_VAL;
      end else begin
        cfg_q[p] <= cfg_d[p];
      end
    end
  end

  // Interrupt enable register.
  always_comb begin
    ien_d = ien_q;
    if (wr_i && (addr_i == `MFGP_OFS_IRQ_EN)) begin
      ien_d = wdata_i[PINS-1:0];
    end
  end

  // Interrupt status: edge bits are sticky and a new edge beats the clear;
  // level bits copy the pin status a cycle late, so they fall one cycle after it drops.
  always_comb begin
    logic clr;
    logic edge_ev;
    clr = 1'b0;
    edge_ev = 1'b0;
    stat_prev_d = pin_stat;
    for (int i = 0; i < PINS; i++) begin
      clr = wr_i && (addr_i == `MFGP_OFS_IRQ_CLR) && wdata_i[i];
      edge_ev = pin_stat[i] ^ stat_prev_q[i];
      if (cfg_q[i].interrupt_trigger_mode) begin
        ists_d[i] = edge_ev || (ists_q[i] && !clr);
      end else begin
        ists_d[i] = pin_stat[i];
      end
    end
  end

  assign irq_o = |(ists_q & ien_q);

  // Read data stand in the cycle after the strobe only.
  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      if (addr_i <= `MFGP_OFS_CTRL_LAST) begin
        for (int i = 0; i < PINS; i++) begin
          if (ctrl_idx == `MFGP_AW'(i)) begin
            rdata_d[$bits(mfgp_pin_cfg_t)-1:0] = cfg_q[i];
          end
        end
      end else if (addr_i == `MFGP_OFS_PIN_STAT) begin
        rdata_d[PINS-1:0] = pin_stat;
      end else if (addr_i == `MFGP_OFS_IRQ_STAT) begin
        rdata_d[PINS-1:0] = ists_q;
      end else if (addr_i == `MFGP_OFS_IRQ_EN) begin
        rdata_d[PINS-1:0] = ien_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      ien_q <= PINS'(`MFGP_IRQ_EN_RST);
    end else begin
      ien_q <= ien_d;
    end
  end

  // The previous status starts low, matching idle pins one to four, which reset pulled down.
  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      ists_q <= '0;
      stat_prev_q <= '0;
    end else begin
      ists_q <= ists_d;
      stat_prev_q <= stat_prev_d;
    end
  end

  // Clearing the read register every idle cycle keeps stale data off the bus.
  always_ff @(posedge clk_i or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule

// >>> bench/mfgp_pads.sv
// Jack, button and peripheral circuits seen at the five pins.
// Assumes the bench chooses which pins an outside circuit drives.
`timescale 1ns/1ps
module mfgp_pads (
  input wire logic clk_i,
  input wire logic [4:0] pad_out_i,
  input wire logic [4:0] pad_oe_i,
  input wire logic [4:0] pu_i,
  input wire logic [4:0] pd_i,
  input wire logic [4:0] ext_drv_i,
  input wire logic [4:0] ext_lvl_i,
  output logic [4:0] pad_in_o
);
  logic [4:0] flt_q = 5'h00;
  // A floating pin toggles, so a stale level never passes for a real one.
  always @(posedge clk_i) flt_q <= ~pad_in_o;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pad_oe_i[i]) pad_in_o[i] = pad_out_i[i];
      else if (ext_drv_i[i]) pad_in_o[i] = ext_lvl_i[i];
      else if (pu_i[i]) pad_in_o[i] = 1'b1;
      else if (pd_i[i]) pad_in_o[i] = 1'b0;
      else pad_in_o[i] = flt_q[i];
    end
  end
endmodule

// >>> bench/mfgp_top_chk.sv
// Port checker for the pin block, with a shadow of its control words.
// Assumes binding into mfgp_top and no write before reset release.
`timescale 1ns/1ps
module mfgp_top_chk
  import mfgp_pkg::*;
#(
  parameter int PINS = 5,
  parameter int DB_TICK_CYCLES = 4,
  parameter int DB_STABLE_TICKS = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [PINS-1:0] pad_in_i,
  input wire logic [PINS-1:0] pad_out_o,
  input wire logic [PINS-1:0] pad_oe_o,
  input wire logic [PINS-1:0] pullup_en_o,
  input wire logic [PINS-1:0] pulldown_en_o,
  input wire mfgp_func_in_t func_i,
  input wire mfgp_func_out_t func_o,
  input wire logic irq_o
);
  logic [15:0] cfg_q [PINS];
  logic [4:0] en_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < PINS; i++) begin
        cfg_q[i] <= i == 3 ? 16'h02a8 : i == 4 ? 16'h01a8 : 16'h00a8;
      end
      en_q <= 5'h00;
    end else if (wr_i) begin
      if (addr_i < 4'h5) cfg_q[addr_i] <= wdata_i;
      if (addr_i == 4'h7) en_q <= wdata_i[4:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence no_read;
    !rd_i;
  endsequence
  rdata_idle_a: assert property (no_read |=> rdata_o == 16'h0000)
    else $error("read data without a read");
  irq_mask_a: assert property (en_q == 5'h00 |-> !irq_o)
    else $error("masked interrupt seen");
  dmic_valid_a: assert property (
    func_o.digital_mic_data_valid == (cfg_q[1][13:8] == 6'h06))
    else $error("mic data valid wrong");
  bclk_sel_a: assert property (
    func_o.bclk_on_pin == (cfg_q[4][13:8] == 6'h01))
    else $error("bit clock select wrong");
  bclk_drv_a: assert property (cfg_q[4][13:8] == 6'h01 |->
    pad_oe_o[4] == func_i.bclk_oe && pad_out_o[4] == func_i.bclk_out)
    else $error("bit clock drive wrong");
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    wire [15:0] c = cfg_q[p];
    wire own = !(p == 4 && c[13:8] == 6'h01);
    wire drv = own && !c[7] && !c[6];
    gp_out_a: assert property (drv && c[13:8] == 6'h00 |->
      pad_oe_o[p] && pad_out_o[p] == c[4]) else $error("bad level");
    dmic_clk_a: assert property (drv && c[13:8] == 6'h06 |->
      pad_out_o[p] == (p == 0 && func_i.digital_mic_clock))
      else $error("bad mic clock");
    od_a: assert property (own && c[6] && pad_oe_o[p] |->
      !pad_out_o[p]) else $error("open drain drives high");
    dir_in_a: assert property (own && c[7] |-> !pad_oe_o[p])
      else $error("input pin driven");
    pulls_a: assert property (
      pullup_en_o[p] == (own && c[2] && !c[3]) &&
      pulldown_en_o[p] == (own && c[3] && !c[2])) else $error("bad pulls");
  end
endmodule

// >>> bench/test_multifunction_gpio_pins.sv
// Self-checking bench for the five-pin block and its pad circuits.
// Assumes the package, the pad model and the checker are compiled first.
`timescale 1ns/1ps
module test_multifunction_gpio_pins;
  import mfgp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_d = 1'b0;
  logic [15:0] rdata_o;
  logic [15:0] v;
  logic [4:0] pad_in_i, pad_out_o, pad_oe_o, pullup_en_o, pulldown_en_o;
  logic [4:0] ext_drv = 5'h00;
  logic [4:0] ext_lvl = 5'h00;
  logic irq_o;
  mfgp_func_in_t func_i = 8'h00;
  mfgp_func_out_t func_o;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h00000036;
  int mismatches = 0;
  int samples_checked = 0;
  mfgp_top #(.DB_TICK_CYCLES(4), .DB_STABLE_TICKS(4)) DUT (.*);
  mfgp_pads u_pads (.clk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pu_i(pullup_en_o), .pd_i(pulldown_en_o), .ext_drv_i(ext_drv),
    .ext_lvl_i(ext_lvl), .pad_in_o(pad_in_i));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge clk_i) begin
    if (rd_d) cmp(rdata_o, exp_q.pop_front());
    rd_d <= rd_i;
  end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    $display("ERROR %0t ns: run did not end", $time);
    mismatches++;
    finish_test();
  end
  initial begin
    tick(16);
    rst_n_i <= 1'b1;
    tick(3);
    for (int i = 0; i < 5; i++) begin
      rd(i[3:0], i == 3 ? 16'h02a8 : i == 4 ? 16'h01a8 : 16'h00a8);
    end
    rd(4'h7, 16'h0000);
    rd(4'hc, 16'h0000);
    cmp({15'h0000, func_o.bclk_on_pin}, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      func_i <= v[7:0];
      wr(i[3:0], {11'h000, v[8], 4'h0});
      tick(1);
      cmp({14'h0000, pad_oe_o[i], pad_out_o[i]}, {14'h0001, v[8]});
      wr(i[3:0], {11'h002, v[9], 4'h0});
      tick(1);
      cmp({15'h0000, pad_oe_o[i]}, {15'h0000, !v[9]});
    end
    for (int k = 0; k < 64; k += (k < 10) ? 1 : 53) begin
      for (int i = 0; i < 2; i++) begin
        v = rnd();
        func_i <= v[7:0];
        wr(i[3:0], {2'b00, k[5:0], 8'h00});
        tick(1);
        if (k == 6 && i == 0) cmp(pad_out_o[0], v[2]);
      end
    end
    for (int k = 0; k < 4; k++) begin
      wr(4'h2, {12'h008, k[1:0], 2'b00});
      tick(1);
      cmp({pullup_en_o[2], pulldown_en_o[2]}, {k == 1, k == 2});
    end
    $display("output and pull tests done");
    ext_drv <= 5'h1f;
    for (int i = 0; i < 5; i++) wr(i[3:0], 16'h03a2);
    wr(4'h7, 16'h001f);
    tick(4);
    wr(4'h8, 16'h001f);
    for (int i = 0; i < 5; i++) begin
      ext_lvl[i] <= 1'b1;
      tick(4);
      rd(4'h6, 16'h0001 << i);
      cmp({15'h0000, irq_o}, 16'h0001);
      wr(4'h8, 16'h0001 << i);
      rd(4'h6, 16'h0000);
      ext_lvl[i] <= 1'b0;
      tick(4);
      rd(4'h6, 16'h0001 << i);
      wr(4'h8, 16'h001f);
    end
    wr(4'h0, 16'h0380);
    tick(4);
    rd(4'h5, 16'h0001);
    wr(4'h8, 16'h001f);
    rd(4'h6, 16'h0001);
    wr(4'h7, 16'h0000);
    tick(1);
    cmp({15'h0000, irq_o}, 16'h0000);
    wr(4'h7, 16'h001f);
    ext_lvl[0] <= 1'b1;
    tick(4);
    rd(4'h6, 16'h0000);
    $display("interrupt tests done");
    wr(4'h1, 16'h03a1);
    tick(20);
    ext_lvl[1] <= 1'b1;
    tick(3);
    ext_lvl[1] <= 1'b0;
    tick(20);
    rd(4'h5, 16'h0000);
    ext_lvl[1] <= 1'b1;
    tick(30);
    rd(4'h5, 16'h0002);
    ext_drv[4] <= 1'b0;
    cmp({15'h0000, func_o.bclk_on_pin}, 16'h0000);
    wr(4'h4, 16'h0144);
    tick(1);
    cmp({func_o.bclk_on_pin, pullup_en_o[4]}, 16'h0002);
    wr(4'h1, 16'h0680);
    tick(4);
    v = {14'h0000, func_o.digital_mic_data_valid, func_o.digital_mic_data};
    cmp(v, 16'h0003);
    ext_lvl[1] <= 1'b0;
    tick(4);
    cmp({func_o.digital_mic_data_valid, func_o.digital_mic_data}, 2'b10);
    $display("debounce and special pin tests done");
    finish_test();
  end
endmodule
bind mfgp_top mfgp_top_chk #(.PINS(PINS), .DB_TICK_CYCLES(DB_TICK_CYCLES),
  .DB_STABLE_TICKS(DB_STABLE_TICKS)) u_chk (.*);
